// ---- core/nsx_alu.sv ----
`timescale 1ns/100ps
`default_nettype none
module nsx_alu (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Decoded instruction
   input wire nsx_pkg::nsx_instr_s instr,
   // File register read port, combinational, addressed by instr.addr
   output logic [6:0] file_raddr,
   input wire logic [7:0] file_rdata,
   // File register write-back
   output nsx_pkg::nsx_fwr_s file_wr,
   // Core state
   output logic [7:0] acc,
   output logic zero_flag
);

   // ----------------------------------------
   // Datapath
   // ----------------------------------------
   logic [7:0] result;
   logic res_zero;
   logic [7:0] acc_q, acc_d;
   logic zero_q, zero_d;
   nsx_pkg::nsx_fwr_s wr_q, wr_d;
   logic is_xor;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // True for both XOR forms, the only ones allowed to touch the zero flag
   function automatic logic op_is_xor(input nsx_pkg::nsx_op_e op);
      return (op == nsx_pkg::NSX_OP_XORL) || (op == nsx_pkg::NSX_OP_XORF);
   endfunction

   // True for the forms that honour the destination select bit
   function automatic logic op_routes(input nsx_pkg::nsx_op_e op);
      return (op == nsx_pkg::NSX_OP_SWAP) || (op == nsx_pkg::NSX_OP_XORF);
   endfunction

   assign file_raddr = instr.addr;

   nsx_logic u_logic (
      .op(instr.op),
      .acc(acc_q),
      .file_data(file_rdata),
      .literal(instr.literal),
      .result(result),
      .zero(res_zero)
   );

   // Next-state: destination routing and flag update
   always_comb begin
      acc_d = acc_q;
      zero_d = zero_q;
      wr_d = '0;
      is_xor = op_is_xor(instr.op);
      if (instr.valid) begin
         if (is_xor) begin
            zero_d = res_zero;
         end
         if (instr.op == nsx_pkg::NSX_OP_XORL) begin
            acc_d = result;
         end else if (op_routes(instr.op)) begin
            // Same routing for swap and register XOR
            if (instr.dest == nsx_pkg::DEST_ACC) begin
               acc_d = result;
            end else begin
               wr_d.we = 1'b1;
               wr_d.addr = instr.addr;
               wr_d.data = result;
            end
         end
      end
   end

   // Registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= nsx_pkg::ACC_RST;
         zero_q <= nsx_pkg::ZERO_RST;
         wr_q <= '0;
      end else begin
         acc_q <= acc_d;
         zero_q <= zero_d;
         wr_q <= wr_d;
      end
   end

   assign acc = acc_q;
   assign zero_flag = zero_q;
   assign file_wr = wr_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // All checks run on the one core clock and stay quiet during reset
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Issue patterns, one per kind of accepted instruction
   sequence swap_acc_s;
      instr.valid && instr.op == nsx_pkg::NSX_OP_SWAP && instr.dest == nsx_pkg::DEST_ACC;
   endsequence

   sequence swap_file_s;
      instr.valid && instr.op == nsx_pkg::NSX_OP_SWAP && instr.dest == nsx_pkg::DEST_FILE;
   endsequence

   sequence xorl_s;
      instr.valid && instr.op == nsx_pkg::NSX_OP_XORL;
   endsequence

   sequence xorf_acc_s;
      instr.valid && instr.op == nsx_pkg::NSX_OP_XORF && instr.dest == nsx_pkg::DEST_ACC;
   endsequence

   sequence xorf_file_s;
      instr.valid && instr.op == nsx_pkg::NSX_OP_XORF && instr.dest == nsx_pkg::DEST_FILE;
   endsequence

   // Nothing accepted: idle, a no-op or a code the decoder should never send
   sequence quiet_s;
      !instr.valid || !(op_routes(instr.op) || op_is_xor(instr.op));
   endsequence

   // ----------------------------------------
   // Nibble swap
   // ----------------------------------------
   // Swapped value lands in the accumulator one cycle after issue
   swap_value_a: assert property (
      swap_acc_s |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
      else $error("swap result wrong");

   // Swap never touches the flag, whatever the destination
   swap_flag_a: assert property (
      instr.valid && instr.op == nsx_pkg::NSX_OP_SWAP |=> $stable(zero_flag))
      else $error("swap changed zero flag");

   // Swap to the file raises the write strobe and leaves the accumulator alone
   swap_file_a: assert property (
      swap_file_s |=> file_wr.we && $stable(acc))
      else $error("swap to file wrong");

   // Write-back carries the swapped value, not the raw operand
   swap_wdata_a: assert property (
      swap_file_s |=> file_wr.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
      else $error("swap write data wrong");

   // Write-back goes to the register that was read
   swap_waddr_a: assert property (
      swap_file_s |=> file_wr.addr == $past(instr.addr))
      else $error("swap write address wrong");

   // Swap into the accumulator must not also write the file
   swap_acc_a: assert property (
      swap_acc_s |=> !file_wr.we)
      else $error("swap to acc wrote file");

   // ----------------------------------------
   // Literal XOR
   // ----------------------------------------
   // Literal form always targets the accumulator, the dest bit is ignored
   xorl_value_a: assert property (
      xorl_s |=> acc == ($past(acc) ^ $past(instr.literal)) && !file_wr.we)
      else $error("literal xor wrong");

   // Zero flag worked out from the operands, independent of the datapath
   xorl_zero_a: assert property (
      xorl_s |=> zero_flag == (($past(acc) ^ $past(instr.literal)) == 8'h00))
      else $error("literal xor zero flag wrong");

   // ----------------------------------------
   // Register XOR
   // ----------------------------------------
   // Accumulator form, no write-back
   xorf_acc_a: assert property (
      xorf_acc_s |=> acc == ($past(acc) ^ $past(file_rdata)) && !file_wr.we)
      else $error("register xor to acc wrong");

   // File form, value and address on the registered write port
   xorf_file_a: assert property (
      xorf_file_s |=> file_wr.we && file_wr.data == ($past(acc) ^ $past(file_rdata))
          && file_wr.addr == $past(instr.addr))
      else $error("register xor to file wrong");

   // File form keeps the accumulator, a stray update would corrupt later ops
   xorf_keep_a: assert property (
      xorf_file_s |=> $stable(acc))
      else $error("register xor to file changed acc");

   // Zero flag follows the result even when it goes to the file
   xorf_zero_a: assert property (
      instr.valid && instr.op == nsx_pkg::NSX_OP_XORF
      |=> zero_flag == (($past(acc) ^ $past(file_rdata)) == 8'h00))
      else $error("register xor zero flag wrong");

   // ----------------------------------------
   // Flags, write port and idle
   // ----------------------------------------
   // Flag agrees with whichever destination took the result
   xor_zero_a: assert property (
      instr.valid && is_xor
      |=> zero_flag == (file_wr.we ? file_wr.data == 8'h00 : acc == 8'h00))
      else $error("zero flag wrong");

   // Only the XOR forms may move the flag
   zero_other_a: assert property (
      !(instr.valid && is_xor) |=> $stable(zero_flag))
      else $error("zero flag moved without xor");

   // A write strobe always traces back to a file-destined routed instruction
   wb_source_a: assert property (
      file_wr.we
      |-> $past(instr.valid && instr.dest == nsx_pkg::DEST_FILE && op_routes(instr.op)))
      else $error("write strobe without source");

   // Idle, no-op and unused codes leave every piece of state alone
   idle_hold_a: assert property (
      quiet_s |=> $stable(acc) && $stable(zero_flag) && !file_wr.we)
      else $error("state changed while idle");

endmodule
`default_nettype wire

// ---- core/nsx_logic.sv ----
`timescale 1ns/100ps
`default_nettype none
module nsx_logic (
   // Operation and operands
   input wire nsx_pkg::nsx_op_e op,
   input wire logic [7:0] acc,
   input wire logic [7:0] file_data,
   input wire logic [7:0] literal,
   // Result
   output logic [7:0] result,
   output logic zero
);

   // Combinational result of the selected operation
   always_comb begin
      unique case (op)
         nsx_pkg::NSX_OP_SWAP: result = {file_data[3:0], file_data[7:4]};
         nsx_pkg::NSX_OP_XORL: result = acc ^ literal;
         nsx_pkg::NSX_OP_XORF: result = acc ^ file_data;
         default: result = 8'h00;
      endcase
   end

   // Zero detect, used only by XOR operations
   assign zero = (result == 8'h00);

endmodule
`default_nettype wire

// ---- core/nsx_pkg.sv ----
package nsx_pkg;

   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // ----------------------------------------
   // Operation codes from the decoder
   // ----------------------------------------
   typedef enum logic [3:0] {
      NSX_OP_NONE = 4'h1,
      NSX_OP_SWAP = 4'h2,
      NSX_OP_XORL = 4'h4,
      NSX_OP_XORF = 4'h8
   } nsx_op_e;

   // Decoded instruction
   typedef struct packed {
      logic valid;
      nsx_op_e op;
      logic dest;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] literal;
   } nsx_instr_s;

   // File register write-back request
   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } nsx_fwr_s;

endpackage

// ---- sim/nibble_swap_xor_alu_ops_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module nibble_swap_xor_alu_ops_tb;
   logic clock, rst_n, zero_flag, m_zero;
   nsx_pkg::nsx_instr_s instr;
   nsx_pkg::nsx_fwr_s file_wr, m_wr;
   logic [6:0] file_raddr;
   logic [7:0] file_rdata, acc, m_acc, src, res;
   logic [7:0] shadow [128];
   int errors = 0;
   int samples_checked = 0;
   nsx_alu nsx_alu_i (.clock(clock), .rst_n(rst_n), .instr(instr), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag));
   nsx_file_model nsx_file_model_i (.clock(clock), .raddr(file_raddr), .rdata(file_rdata),
      .wr(file_wr));
   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         errors++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   function automatic logic [7:0] swap_of(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Random instruction stream, literal set to the accumulator every eighth step so a literal XOR there gives zero
   initial begin
      instr = '0;
      rst_n = 1'b0;
      m_acc = 8'h00;
      m_zero = 1'b0;
      for (int i = 0; i < 128; i++) shadow[i] = 8'(i * 37);
      void'($urandom(83981));
      repeat (8) @(negedge clock);
      check({7'h00, zero_flag, acc}, 16'h0000); // reset values
      rst_n = 1'b1;
      for (int n = 0; n < 600; n++) begin
         instr.valid = ($urandom_range(7) != 0);
         instr.op = nsx_pkg::nsx_op_e'(4'h1 << $urandom_range(4));
         instr.dest = 1'($urandom);
         instr.addr = 7'($urandom);
         instr.literal = (n % 8 == 0) ? m_acc : 8'($urandom);
         src = shadow[instr.addr];
         m_wr = '0;
         res = 8'h00;
         if (instr.valid) begin
            case (instr.op)
               nsx_pkg::NSX_OP_SWAP: res = swap_of(src);
               nsx_pkg::NSX_OP_XORL: res = m_acc ^ instr.literal;
               nsx_pkg::NSX_OP_XORF: res = m_acc ^ src;
               default: ;
            endcase
            if (instr.op inside {nsx_pkg::NSX_OP_XORL, nsx_pkg::NSX_OP_XORF}) m_zero = (res == 0);
            if (instr.op inside {nsx_pkg::NSX_OP_SWAP, nsx_pkg::NSX_OP_XORF} && instr.dest)
               m_wr = '{1'b1, instr.addr, res};
            else if (instr.op inside {nsx_pkg::NSX_OP_SWAP, nsx_pkg::NSX_OP_XORF,
               nsx_pkg::NSX_OP_XORL}) m_acc = res;
         end
         if (m_wr.we) shadow[m_wr.addr] = m_wr.data;
         @(negedge clock);
         check({8'h00, acc}, {8'h00, m_acc});
         check({15'h0000, zero_flag}, {15'h0000, m_zero});
         check(file_wr, m_wr);
         check({9'h000, file_raddr}, {9'h000, instr.addr});
      end
      $display("Random instruction test done");
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- sim/nsx_file_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module nsx_file_model (
   // Clock
   input wire logic clock,
   // Read and write ports
   input wire logic [6:0] raddr,
   output logic [7:0] rdata,
   input wire nsx_pkg::nsx_fwr_s wr
);
   logic [7:0] mem [128];
   // Known contents, mirrored by the bench
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
   end
   // Read is combinational, same cycle
   assign rdata = mem[raddr];
   // Write lands on the falling edge so a back-to-back reader sees it
   always @(negedge clock) begin
      if (wr.we === 1'b1) mem[wr.addr] <= wr.data;
   end
endmodule
`default_nettype wire
